// *** src/tbf_map.svh ***
`ifndef TBF_MAP_SVH
`define TBF_MAP_SVH

// register byte offsets
`define TBF_OFS_LINK 12'h004
`define TBF_OFS_FLOW 12'h008
`define TBF_OFS_BASE 12'h00C
`define TBF_OFS_MODE 12'hF00
`define TBF_OFS_TAGSET 12'hFA0
`define TBF_OFS_TAGCLR 12'hFA4
`define TBF_OFS_LOCKACC 12'hFB0
`define TBF_OFS_LOCKSTAT 12'hFB4
`define TBF_OFS_AUTH 12'hFB8

// flow register fields
`define TBF_FLOW_WM_HI 31
`define TBF_FLOW_WM_LO 3
`define TBF_FLOW_HALT 1
`define TBF_FLOW_STOP 0

// link register fields
`define TBF_LINK_EN 0
`define TBF_LINK_HALT_REQUEST_BIT 1
`define TBF_LINK_BEGIN_ALLOW 2
`define TBF_LINK_STOPPED 3

// reset values
`define TBF_RST_WM 29'h0000_0000
`define TBF_RST_ZERO 32'h0000_0000

// buffer origin: top of lower ram less a quarter of ram size
`define TBF_RAM_TOP 32'h2000_0000
`define TBF_RAM_BYTES 32'h0000_4000
`define TBF_RAM_DIV 32'h0000_0004

`endif

// *** src/tbf_pkg.sv ***
package tbf_pkg;

	// watermark and pointer share one encoding
	typedef logic [28:0] tbf_ptr_t;

	// bus answer sequencer, one-hot
	typedef enum logic [1:0]
	{
		TBF_IDLE = 2'b01,
		TBF_ANSWER = 2'b10
	} tbf_bus_state_t;

endpackage : tbf_pkg

// *** src/tbf_pin_sync.sv ***
`timescale 1ns/10ps

// three-stage pin synchroniser with agreement filter
module tbf_pin_sync
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic pin_in,
	output logic level_out
);

	logic stage1;
	logic stage2;
	logic stage3;

	// shift chain; stage1 feeds only stage2
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			stage1 <= 1'b0;
			stage2 <= 1'b0;
			stage3 <= 1'b0;
		end
		else if (ce_in)
		begin
			stage1 <= pin_in;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// accept a change once stages two and three agree
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			level_out <= 1'b0;
		end
		else if (ce_in && (stage2 == stage3))
		begin
			level_out <= stage3;
		end
	end

endmodule : tbf_pin_sync

// *** src/tbf_flow_regs.sv ***
// Contract
// [R1] after a watermark stop, tracing stays off until pointer rewrite or autostop cleared; the code also releases on a write of a different watermark
// [R2] watermark sits in flow bits 31..3, same encoding as the write pointer
// [R3] pointer equal to watermark fires every enabled watermark action
// [R4] halt-on-watermark bit 1 plus match sets the halt request bit
// [R5] external halt line asserted only while invasive debug allow is high
// [R6] stop-on-watermark bit 0 plus match clears trace enable
// [R7] agent places the watermark below the last buffer entry when halting
// [R8] flow bit 2 and auth bits 31..4 read zero, writes ignored
// [R9] base register read-only, returns ram top minus quarter of ram size
// [R10] integration mode control always reads zero
// [R11] claim set reads zero, writes have no effect
// [R12] claim clear reads zero, writing ones changes nothing
// [R13] lock access and lock status both read zero
// [R14] auth bits 3:2 noninvasive, 1:0 invasive; 10 disabled, 11 enabled
// [R15] auth bits 3 and 1 always read one
// [R16] auth bit 2 is noninvasive or invasive allow, bit 0 invasive allow
// [R17] watermark-stopped trace ignores the trace begin input
// [R18] compare on each pointer update, act in that same cycle
`timescale 1ns/10ps
`include "tbf_map.svh"

module tbf_flow_regs
	import tbf_pkg::*;
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic [28:0] pointer_in,
	input wire logic pointer_update_in,
	input wire logic pointer_sw_write_in,
	input wire logic trace_begin_input_in,
	input wire logic invasive_debug_allow_in,
	input wire logic noninvasive_debug_allow_in,
	output logic trace_enable_out,
	output logic halt_request_bit_out,
	output logic external_halt_line_out,
	output logic watermark_stopped_out
);

	////////////////////////////////////////////////////////////////////
	// declarations

	tbf_bus_state_t bus_state;
	tbf_bus_state_t next_bus_state;
	tbf_ptr_t watermark;
	logic auto_halt;
	logic auto_stop;
	logic trace_enable;
	logic halt_request_bit;
	logic begin_input_allow;
	logic wm_stopped;
	logic begin_level;
	logic invasive_allow;
	logic noninvasive_allow;
	logic access;
	logic commit;
	logic wr_commit;
	logic hit_flow;
	logic hit_link;
	logic hit_mapped;
	logic wr_flow;
	logic wr_link;
	logic wm_match;
	logic stop_match;
	logic halt_match;
	logic stop_release;
	logic [31:0] read_value;
	logic [31:0] flow_value;
	logic [31:0] link_value;
	logic [31:0] auth_value;
	logic [31:0] base_value;

	////////////////////////////////////////////////////////////////////
	// pin synchronisers

	// trace begin pin
	tbf_pin_sync u_sync_begin
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.pin_in(trace_begin_input_in),
		.level_out(begin_level)
	);

	// invasive debug allow pin
	tbf_pin_sync u_sync_invasive
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.pin_in(invasive_debug_allow_in),
		.level_out(invasive_allow)
	);

	// noninvasive debug allow pin
	tbf_pin_sync u_sync_noninvasive
	(
		.clk_in(clk_in),
		.sys_rst_in(sys_rst_in),
		.ce_in(ce_in),
		.pin_in(noninvasive_debug_allow_in),
		.level_out(noninvasive_allow)
	);

	////////////////////////////////////////////////////////////////////
	// bus sequencing

	// access phase seen, and the edge where it completes
	assign access = psel_in && penable_in;
	assign commit = access && pready_out;
	assign wr_commit = commit && pwrite_in;

	// one wait state, then answer
	always_comb
	begin
		next_bus_state = bus_state;
		case (bus_state)
			TBF_IDLE:
			begin
				if (access)
				begin
					next_bus_state = TBF_ANSWER;
				end
			end
			TBF_ANSWER:
			begin
				next_bus_state = TBF_IDLE;
			end
			default:
			begin
				next_bus_state = TBF_IDLE;
			end
		endcase
	end

	// state register
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			bus_state <= TBF_IDLE;
		end
		else if (ce_in)
		begin
			bus_state <= next_bus_state;
		end
	end

	////////////////////////////////////////////////////////////////////
	// address decode

	// byte address decode, low two bits ignored
	always_comb
	begin
		hit_flow = 1'b0;
		hit_link = 1'b0;
		hit_mapped = 1'b1;
		read_value = `TBF_RST_ZERO;
		if (paddr_in[11:2] == `TBF_OFS_FLOW >> 2)
		begin
			hit_flow = 1'b1;
			read_value = flow_value;
		end
		else if (paddr_in[11:2] == `TBF_OFS_LINK >> 2)
		begin
			hit_link = 1'b1;
			read_value = link_value;
		end
		else if (paddr_in[11:2] == `TBF_OFS_BASE >> 2)
		begin
			read_value = base_value; // R9
		end
		else if (paddr_in[11:2] == `TBF_OFS_AUTH >> 2)
		begin
			read_value = auth_value; // R14
		end
		else if (paddr_in[11:2] == `TBF_OFS_MODE >> 2)
		begin
			read_value = `TBF_RST_ZERO; // R10
		end
		else if (paddr_in[11:2] == `TBF_OFS_TAGSET >> 2)
		begin
			read_value = `TBF_RST_ZERO; // R11
		end
		else if (paddr_in[11:2] == `TBF_OFS_TAGCLR >> 2)
		begin
			read_value = `TBF_RST_ZERO; // R12
		end
		else if (paddr_in[11:2] == `TBF_OFS_LOCKACC >> 2)
		begin
			read_value = `TBF_RST_ZERO; // R13
		end
		else if (paddr_in[11:2] == `TBF_OFS_LOCKSTAT >> 2)
		begin
			read_value = `TBF_RST_ZERO; // R13
		end
		else
		begin
			hit_mapped = 1'b0;
		end
	end

	// only flow and link hold writable state
	assign wr_flow = wr_commit && hit_flow;
	assign wr_link = wr_commit && hit_link;

	////////////////////////////////////////////////////////////////////
	// read views

	// flow: watermark, zero bit 2, halt and stop enables
	assign flow_value = {watermark, 1'b0, auto_halt, auto_stop}; // R2 R8

	// link: trace enable, halt request, begin allow, stopped flag
	assign link_value = {28'h000_0000, wm_stopped, begin_input_allow,
		halt_request_bit, trace_enable};

	// hardwired origin of the trace buffer
	assign base_value = `TBF_RAM_TOP - (`TBF_RAM_BYTES / `TBF_RAM_DIV); // R9

	// permission report from synchronised pins
	assign auth_value = {28'h000_0000, 1'b1, // R8 R15
		noninvasive_allow || invasive_allow, // R16
		1'b1, invasive_allow}; // R15 R16

	////////////////////////////////////////////////////////////////////
	// bus answer registers

	// answer, data and error raised in the wait cycle
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			pready_out <= 1'b0;
			prdata_out <= `TBF_RST_ZERO;
			pslverr_out <= 1'b0;
		end
		else if (ce_in)
		begin
			pready_out <= (next_bus_state == TBF_ANSWER);
			if (access && (bus_state == TBF_IDLE))
			begin
				prdata_out <= pwrite_in ? `TBF_RST_ZERO : read_value;
				pslverr_out <= !hit_mapped;
			end
			else
			begin
				prdata_out <= `TBF_RST_ZERO;
				pslverr_out <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// flow register

	// watermark and enables; bit 2 has no storage
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			watermark <= `TBF_RST_WM;
			auto_halt <= 1'b0;
			auto_stop <= 1'b0;
		end
		else if (ce_in && wr_flow)
		begin
			watermark <= pwdata_in[`TBF_FLOW_WM_HI:`TBF_FLOW_WM_LO]; // R2
			auto_halt <= pwdata_in[`TBF_FLOW_HALT];
			auto_stop <= pwdata_in[`TBF_FLOW_STOP];
		end
	end

	////////////////////////////////////////////////////////////////////
	// watermark compare

	// compare only on a pointer update, act at the same edge
	assign wm_match = pointer_update_in && (pointer_in == watermark); // R18
	assign stop_match = wm_match && auto_stop; // R3 R6
	assign halt_match = wm_match && auto_halt; // R3 R4

	// software releases the stop by rewriting pointer or writing a different watermark,
	// or by clearing the stop enable
	assign stop_release = pointer_sw_write_in
		|| (wr_flow && !pwdata_in[`TBF_FLOW_STOP])
		|| (wr_flow && (pwdata_in[`TBF_FLOW_WM_HI:`TBF_FLOW_WM_LO]
		!= watermark));

	// sticky stopped flag; a new stop beats a release
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			wm_stopped <= 1'b0;
		end
		else if (ce_in)
		begin
			if (stop_match)
			begin
				wm_stopped <= 1'b1; // R1
			end
			else if (stop_release)
			begin
				wm_stopped <= 1'b0; // R1
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// trace enable

	// stop wins, then software, then the begin pin
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			trace_enable <= 1'b0;
		end
		else if (ce_in)
		begin
			if (stop_match)
			begin
				trace_enable <= 1'b0; // R6
			end
			else if (wm_stopped && !stop_release)
			begin
				trace_enable <= 1'b0; // R1 R17
			end
			else if (wr_link)
			begin
				trace_enable <= pwdata_in[`TBF_LINK_EN];
			end
			else if (begin_input_allow && begin_level)
			begin
				trace_enable <= 1'b1;
			end
		end
	end

	// begin pin permission
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			begin_input_allow <= 1'b0;
		end
		else if (ce_in && wr_link)
		begin
			begin_input_allow <= pwdata_in[`TBF_LINK_BEGIN_ALLOW];
		end
	end

	////////////////////////////////////////////////////////////////////
	// halt request

	// watermark set beats a software clear in the same cycle
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			halt_request_bit <= 1'b0;
		end
		else if (ce_in)
		begin
			if (halt_match)
			begin
				halt_request_bit <= 1'b1; // R4
			end
			else if (wr_link)
			begin
				halt_request_bit <= pwdata_in[`TBF_LINK_HALT_REQUEST_BIT];
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// outputs

	// registered copies toward the core and trace path; the halt line is the halt request gated by invasive allow
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
		begin
			trace_enable_out <= 1'b0;
			halt_request_bit_out <= 1'b0;
			external_halt_line_out <= 1'b0;
			watermark_stopped_out <= 1'b0;
		end
		else if (ce_in)
		begin
			trace_enable_out <= trace_enable;
			halt_request_bit_out <= halt_request_bit;
			external_halt_line_out <= halt_request_bit
				&& invasive_allow; // R5
			watermark_stopped_out <= wm_stopped;
		end
	end

endmodule : tbf_flow_regs

// *** sim/tbf_flow_regs_props.sv ***
`timescale 1ns/10ps
`include "tbf_map.svh"

module tbf_flow_regs_props
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic pslverr_out,
	input wire logic [28:0] pointer_in,
	input wire logic pointer_update_in,
	input wire logic pointer_sw_write_in,
	input wire logic trace_enable_out,
	input wire logic halt_request_bit_out,
	input wire logic external_halt_line_out,
	input wire logic watermark_stopped_out
);
	logic [31:0] flow;
	logic rd;
	logic wr;
	logic [11:0] a;
	default clocking @(posedge clk_in); endclocking
	default disable iff (sys_rst_in);
	// completed reads and writes, word address
	assign rd = pready_out && !pwrite_in;
	assign wr = pready_out && pwrite_in;
	assign a = {paddr_in[11:2], 2'b00};
	// shadow of the flow register as last written
	always_ff @(posedge clk_in)
	begin
		if (sys_rst_in)
			flow <= 32'h0;
		else if (wr && a == `TBF_OFS_FLOW)
			flow <= pwdata_in;
	end
	sequence hit;
		pointer_update_in && pointer_in == flow[31:3];
	endsequence
	chk_ready_once: assert property (psel_in && penable_in && !pready_out
		|=> pready_out) else $error("no ready after access");
	chk_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	chk_err_ready: assert property (pslverr_out |-> pready_out)
		else $error("error without ready");
	chk_stop_match: assert property (hit and flow[0] |-> ##2
		watermark_stopped_out && !trace_enable_out) else $error("no stop");
	chk_halt_match: assert property (hit and flow[1] |-> ##2
		halt_request_bit_out) else $error("no halt request");
	chk_stop_hold: assert property (watermark_stopped_out
		|-> !trace_enable_out) else $error("trace on while stopped");
	chk_stop_release: assert property ($fell(watermark_stopped_out)
		|-> $past(pointer_sw_write_in, 2) || $past(wr, 2))
		else $error("stop released without cause");
	chk_halt_gate: assert property (external_halt_line_out
		|-> halt_request_bit_out) else $error("halt line without request");
	chk_zero_regs: assert property (rd && a inside {`TBF_OFS_MODE,
		`TBF_OFS_TAGSET, `TBF_OFS_TAGCLR, `TBF_OFS_LOCKACC,
		`TBF_OFS_LOCKSTAT} |-> prdata_out == 32'h0)
		else $error("fixed register not zero");
	chk_base_val: assert property (rd && a == `TBF_OFS_BASE
		|-> prdata_out == 32'h1FFF_F000) else $error("wrong origin");
	chk_auth_bits: assert property (rd && a == `TBF_OFS_AUTH
		|-> prdata_out[31:4] == 28'h0 && prdata_out[3] && prdata_out[1])
		else $error("wrong fixed permission bits");
	chk_flow_read: assert property (rd && a == `TBF_OFS_FLOW
		|-> prdata_out == (flow & 32'hFFFF_FFFB)) else $error("flow bad");
endmodule : tbf_flow_regs_props

bind tbf_flow_regs tbf_flow_regs_props i_props (.*);

// *** sim/tbf_core_model.sv ***
`timescale 1ns/10ps

module tbf_core_model
(
	input wire logic clk_in,
	input wire logic sys_rst_in,
	input wire logic run_in,
	input wire logic halt_in,
	input wire logic load_in,
	input wire logic [28:0] load_val_in,
	input wire logic [3:0] gap_in,
	output logic [28:0] ptr_out,
	output logic upd_out,
	output logic sw_out,
	output logic halted_out
);
	logic [3:0] cnt;
	// pointer steps every gap_in+1 cycles until the halt takes hold
	always_ff @(posedge clk_in)
	begin
		upd_out <= 1'b0;
		sw_out <= load_in;
		halted_out <= halt_in;
		cnt <= cnt + 4'h1;
		if (sys_rst_in)
		begin
			ptr_out <= 29'h0;
			cnt <= 4'h0;
		end
		else if (load_in)
			ptr_out <= load_val_in;
		else if (run_in && !halted_out && cnt >= gap_in)
		begin
			ptr_out <= ptr_out + 29'h1;
			upd_out <= 1'b1;
			cnt <= 4'h0;
		end
	end
endmodule : tbf_core_model

// *** sim/trace_buffer_flow_and_id_regs_test.sv ***
`timescale 1ns/10ps
`include "tbf_map.svh"

module trace_buffer_flow_and_id_regs_test;
	logic clk_in, sys_rst_in, ce_in, psel_in, penable_in, pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, rd;
	logic pready_out, pslverr_out, er, load, halted;
	logic [28:0] pointer_in, load_val;
	logic pointer_update_in, pointer_sw_write_in, trace_begin_input_in;
	logic invasive_debug_allow_in, noninvasive_debug_allow_in;
	logic trace_enable_out, halt_request_bit_out, external_halt_line_out;
	logic watermark_stopped_out;
	logic [3:0] gap;
	int bad_count, total_checks;
	tbf_flow_regs i_tbf_flow_regs (.*);
	tbf_core_model i_tbf_core_model (.clk_in, .sys_rst_in,
		.run_in(trace_enable_out), .halt_in(external_halt_line_out),
		.load_in(load), .load_val_in(load_val), .gap_in(gap),
		.ptr_out(pointer_in), .upd_out(pointer_update_in),
		.sw_out(pointer_sw_write_in), .halted_out(halted));
	////////////////////////////////////////////////////////////////
	task tally_and_finish;
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : tally_and_finish
	task chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("wrong value %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one transfer; held until ready is sampled
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_in);
		psel_in <= 1'b1;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready_out !== 1'b1 && n < 20);
		chk(pready_out, 1'b1);
		if (pready_out !== 1'b1)
			tally_and_finish;
		rd = prdata_out;
		er = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask : apb
	// bounded wait on stop (0) or halt line (1)
	task wt(input int s);
		int n;
		n = 0;
		while ((s ? external_halt_line_out : watermark_stopped_out) !== 1'b1
			&& n < 300)
		begin
			@(posedge clk_in);
			n++;
		end
		chk(n < 300, 1'b1);
		if (n >= 300)
			tally_and_finish;
	endtask : wt
	task ptr_load;
		@(posedge clk_in);
		load <= 1'b1;
		@(posedge clk_in);
		load <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : ptr_load
	////////////////////////////////////////////////////////////////
	task t_fixed;
		logic [11:0] ofs [6];
		ofs = '{`TBF_OFS_BASE, `TBF_OFS_MODE,
			`TBF_OFS_TAGSET, `TBF_OFS_TAGCLR, `TBF_OFS_LOCKACC,
			`TBF_OFS_LOCKSTAT};
		apb(1'b0, `TBF_OFS_LINK, 32'h0);
		chk(rd, 32'h0);
		foreach (ofs[i])
		begin
			apb(1'b1, ofs[i], 32'hFFFF_FFFF);
			apb(1'b0, ofs[i], 32'h0);
			chk(rd, i ? 32'h0 : 32'h1FFF_F000);
			chk(er, 1'b0);
		end
		apb(1'b0, 12'h010, 32'h0);
		chk(er, 1'b1);
		apb(1'b1, `TBF_OFS_FLOW, 32'hFFFF_FFFF);
		apb(1'b0, `TBF_OFS_FLOW, 32'h0);
		chk(rd, 32'hFFFF_FFFB);
	endtask : t_fixed
	task t_auth;
		for (int k = 0; k < 4; k++)
		begin
			@(posedge clk_in);
			invasive_debug_allow_in <= k[0];
			noninvasive_debug_allow_in <= k[1];
			repeat (8) @(posedge clk_in);
			apb(1'b1, `TBF_OFS_AUTH, 32'hFFFF_FFFF);
			apb(1'b0, `TBF_OFS_AUTH, 32'h0);
			chk(rd, {28'h0, 1'b1, k[0] | k[1], 1'b1, k[0]});
		end
	endtask : t_auth
	task t_stop;
		apb(1'b1, `TBF_OFS_FLOW, {29'h5, 3'b001});
		apb(1'b1, `TBF_OFS_LINK, 32'h5);
		wt(0);
		chk(trace_enable_out, 1'b0);
		chk(pointer_in, 29'h5);
		@(posedge clk_in);
		trace_begin_input_in <= 1'b1;
		apb(1'b1, `TBF_OFS_LINK, 32'h5);
		repeat (8) @(posedge clk_in);
		apb(1'b0, `TBF_OFS_LINK, 32'h0);
		chk(rd[3:0], 4'hC);
		ptr_load;
		chk(watermark_stopped_out, 1'b0);
		chk(trace_enable_out, 1'b1);
		wt(0);
		apb(1'b1, `TBF_OFS_FLOW, {29'h5, 3'b000});
		repeat (2) @(posedge clk_in);
		chk(watermark_stopped_out, 1'b0);
		trace_begin_input_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		apb(1'b1, `TBF_OFS_LINK, 32'h0);
	endtask : t_stop
	task t_halt;
		ptr_load;
		// watermark kept well below the buffer end
		apb(1'b1, `TBF_OFS_FLOW, {29'h3, 3'b010});
		apb(1'b1, `TBF_OFS_LINK, 32'h1);
		wt(1);
		chk(halt_request_bit_out, 1'b1);
		chk(trace_enable_out, 1'b1);
		@(posedge clk_in);
		invasive_debug_allow_in <= 1'b0;
		repeat (8) @(posedge clk_in);
		chk(external_halt_line_out, 1'b0);
		chk(halt_request_bit_out, 1'b1);
	endtask : t_halt
	////////////////////////////////////////////////////////////////
	// clock, watchdog and main sequence
	initial
	begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial
	begin
		#200000;
		bad_count++;
		tally_and_finish;
	end
	initial
	begin
		{psel_in, penable_in, pwrite_in, load, trace_begin_input_in} = '0;
		{invasive_debug_allow_in, noninvasive_debug_allow_in} = '0;
		paddr_in = 12'h0;
		pwdata_in = 32'h0;
		load_val = 29'h0;
		gap = 4'h3;
		ce_in = 1'b1;
		sys_rst_in = 1'b1;
		repeat (10) @(posedge clk_in);
		sys_rst_in <= 1'b0;
		t_fixed;
		t_auth;
		t_stop;
		t_halt;
		tally_and_finish;
	end
endmodule : trace_buffer_flow_and_id_regs_test
